// ===== hdl/swc_pkg.sv
// Package for the sleep and wake-up controller: map, fields, states
package swc_pkg;
  // Register byte offsets
  localparam logic [7:0] SWC_CTRL_OFS = 8'h00;
  localparam logic [7:0] SWC_STAT_OFS = 8'h04;
  localparam logic [7:0] SWC_IRQ_STAT_OFS = 8'h08;
  localparam logic [7:0] SWC_IRQ_MASK_OFS = 8'h0c;
  localparam logic [7:0] SWC_SRC_EN_OFS = 8'h10;
  localparam int SWC_ADDR_W = 8;
  // Wake source indexes
  localparam int SWC_NSRC = 12;
  localparam int SRC_EXT_PIN = 0;
  localparam int SRC_PORT_CHG = 1;
  localparam int SRC_PAR_SLAVE = 2;
  localparam int SRC_CAPTURE = 3;
  localparam int SRC_STARTSTOP = 4;
  localparam int SRC_SERIAL_SLAVE = 5;
  localparam int SRC_USART_SYNC = 6;
  localparam int SRC_EE_WRITE = 7;
  localparam int SRC_TIMER_ONE = 8;
  localparam int SRC_SPECIAL_TRIG = 9;
  localparam int SRC_ADC = 10;
  localparam int SRC_CLOCKED = 11;
  // Control register fields
  localparam int CTRL_WDOG_EN = 0;
  localparam int CTRL_GLOBAL_IRQ_EN = 1;
  localparam int CTRL_T1_ASYNC = 2;
  localparam int CTRL_ADC_RC = 3;
  // Status register fields
  localparam int STAT_TIMEOUT = 0;
  localparam int STAT_POWERDOWN = 1;
  localparam int STAT_ASLEEP = 2;
  localparam int STAT_WAKE_IRQ = 3;
  localparam int STAT_WAKE_WDOG = 4;
  // Interrupt status events
  localparam int EV_SLEEP_IN = 0;
  localparam int EV_WAKE = 1;
  localparam int EV_WDOG_RST = 2;
  localparam int EV_NOP_SLEEP = 3;
  localparam int SWC_NEV = 4;
  // Reset values
  localparam logic [3:0] CTRL_RST = 4'h1;
  localparam logic [SWC_NSRC-1:0] SRC_EN_RST = 12'h000;
  // Interrupt vector address
  localparam logic [12:0] SWC_IRQ_VECTOR = 13'h0004;
  localparam logic [12:0] SWC_PC_STEP = 13'h0001;
  // Controller states
  typedef enum logic [1:0] {SWC_RUN, SWC_SLEEP, SWC_POST} swc_state_t;
endpackage : swc_pkg

// ===== hdl/swc_sync.sv
// Three-flop input synchroniser with second/third agreement
`timescale 1ns/1ps
`default_nettype none
module swc_sync #(
  parameter int W = 1
) (
  input wire logic clk,
  input wire logic rst_b,
  input wire logic [W-1:0] d,
  output logic [W-1:0] q
);
  // Stage one is read only by stage two
  logic [W-1:0] s1;
  logic [W-1:0] s2;
  logic [W-1:0] s3;

  // Shift chain
  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      s1 <= '0;
      s2 <= '0;
      s3 <= '0;
    end else begin
      s1 <= d;
      s2 <= s1;
      s3 <= s2;
    end
  end

  // Output moves only where stages two and three agree
  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      q <= '0;
    end else begin
      q <= (s2 & s3) | (q & (s2 | s3));
    end
  end
endmodule : swc_sync
`default_nettype wire

// ===== hdl/swc_top.sv
// Sleep entry, wake-up decision and status flags with Wishbone registers
// How it works
// [R1] Wake on clear pin, watchdog, or interrupt
// [R2] Clear pin resets fully; others resume
// [R3] Power-down flag set at power-up, cleared by sleep
// [R4] Watchdog wake clears time-out flag
// [R5] Listed peripheral interrupts may wake
// [R6] Timer one async only; converter RC only
// [R7] Clocked peripherals raise nothing asleep
// [R8] Sleep pre-fetches next address
// [R9] Individual enable gates wake; global ignored
// [R10] Global enable picks resume or vector
// [R11] Pending enabled flag turns sleep into no-op
// [R12] Late interrupt: full sleep, immediate wake
// [R13] Software clears watchdog before sleep
// [R14] Sleep clears watchdog, sets time-out, freezes pins
// [R15] Watchdog resets awake, wakes asleep
// [R16] Wake request is OR of flag-and-enable
//
// Our own choices: the placing of the registers and register access over Wishbone.
`timescale 1ns/1ps
`default_nettype none
module swc_top
  import swc_pkg::*;
(
  input wire logic clk,
  input wire logic rst_b,
  // Wishbone slave
  input wire logic wb_cyc_i,
  input wire logic wb_stb_i,
  input wire logic wb_we_i,
  input wire logic [SWC_ADDR_W-1:0] wb_adr_i,
  input wire logic [3:0] wb_sel_i,
  input wire logic [31:0] wb_dat_i,
  output logic [31:0] wb_dat_o,
  output logic wb_ack_o,
  // Sequencer side
  input wire logic sleep_exec,
  input wire logic watchdog_clear_instr,
  input wire logic [12:0] pc,
  // Outside pins and sources
  input wire logic master_clear_pin_b,
  input wire logic watchdog_timeout,
  input wire logic [SWC_NSRC-1:0] irq_flags,
  // Results
  output logic [12:0] fetch_addr,
  output logic core_halt,
  output logic osc_enable,
  output logic pin_hold,
  output logic watchdog_clear,
  output logic device_reset,
  output logic branch_vector,
  output logic timeout_flag,
  output logic powerdown_flag,
  output logic irq
);
  // Synchronised pin and source levels
  logic master_clear_b_s;
  logic [SWC_NSRC-1:0] flags_s;
  logic wdog_s;
  // Registers
  logic [3:0] ctrl;
  logic [SWC_NSRC-1:0] src_en;
  logic [SWC_NEV-1:0] irq_stat;
  logic [SWC_NEV-1:0] irq_mask;
  logic wake_irq;
  logic wake_wdog;
  swc_state_t state;
  // Wake decode
  logic [SWC_NSRC-1:0] src_ok;
  logic wake_req;
  logic wdog_hit;
  logic [SWC_NEV-1:0] ev;
  logic sleep_go;
  logic sleep_nop;
  logic wb_wr;
  logic wb_rd;
  logic wdog_d;

  // Byte-enable merge for writable words
  function automatic logic [31:0] swc_merge(input logic [31:0] old, input logic [31:0] nw, input logic [3:0] sel);
    logic [31:0] r;
    r = old;
    for (int i = 0; i < 4; i++) begin
      if (sel[i]) begin
        r[i*8 +: 8] = nw[i*8 +: 8];
      end
    end
    return r;
  endfunction : swc_merge

  // Pin and source synchronisers; all arrive from outside this clock
  swc_sync #(.W(SWC_NSRC + 2)) u_sync (
    .clk(clk),
    .rst_b(rst_b),
    .d({master_clear_pin_b, watchdog_timeout, irq_flags}),
    .q({master_clear_b_s, wdog_s, flags_s})
  );

  // Which sources may wake at all in the present mode
  always_comb begin
    src_ok = src_en; // R9
    src_ok[SRC_TIMER_ONE] = src_en[SRC_TIMER_ONE] & ctrl[CTRL_T1_ASYNC]; // R6
    src_ok[SRC_SPECIAL_TRIG] = src_en[SRC_SPECIAL_TRIG] & ctrl[CTRL_T1_ASYNC]; // R6
    src_ok[SRC_ADC] = src_en[SRC_ADC] & ctrl[CTRL_ADC_RC]; // R6
    // Clocked peripherals are dead while asleep
    if (state == SWC_SLEEP) begin
      src_ok[SRC_CLOCKED] = 1'b0; // R7
    end
  end

  // Wake request ignores the global enable
  assign wake_req = |(flags_s & src_ok); // R16 R5 R9
  assign wdog_hit = wdog_s & ~wdog_d & ctrl[CTRL_WDOG_EN];
  assign sleep_go = (state == SWC_RUN) & sleep_exec & ~wake_req; // R12
  assign sleep_nop = (state == SWC_RUN) & sleep_exec & wake_req; // R11
  assign wb_wr = wb_cyc_i & wb_stb_i & wb_we_i & ~wb_ack_o;
  assign wb_rd = wb_cyc_i & wb_stb_i & ~wb_we_i & ~wb_ack_o;

  // Watchdog edge reference, counts one time-out once
  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      wdog_d <= 1'b0;
    end else begin
      wdog_d <= wdog_s;
    end
  end

  // Sleep state machine
  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      state <= SWC_RUN;
    end else if (!master_clear_b_s) begin
      state <= SWC_RUN; // R2
    end else begin
      unique case (state)
        SWC_RUN: begin
          if (sleep_go) begin
            state <= SWC_SLEEP;
          end
        end
        SWC_SLEEP: begin
          // Late interrupt or watchdog leaves at once
          if (wake_req || wdog_hit) begin
            state <= SWC_POST; // R1 R12
          end
        end
        SWC_POST: begin
          // Instruction after sleep runs before any vector
          state <= SWC_RUN; // R10
        end
      endcase
    end
  end

  // Wake cause record
  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      wake_irq <= 1'b0;
      wake_wdog <= 1'b0;
    end else if (state == SWC_SLEEP && (wake_req || wdog_hit)) begin
      wake_irq <= wake_req;
      wake_wdog <= wdog_hit & ~wake_req;
    end
  end

  // Status flags; power-up sets power-down flag
  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      timeout_flag <= 1'b1;
      powerdown_flag <= 1'b1; // R3
    end else if (!master_clear_b_s) begin
      // Pin reset keeps both flags for cause detection
      timeout_flag <= timeout_flag;
    end else if (sleep_go) begin
      timeout_flag <= 1'b1; // R14
      powerdown_flag <= 1'b0; // R3 R14
    end else if (watchdog_clear_instr) begin
      timeout_flag <= 1'b1;
      powerdown_flag <= 1'b1;
    end else if (wdog_hit) begin
      timeout_flag <= 1'b0; // R4 R15
    end
  end

  // Core control outputs
  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      core_halt <= 1'b0;
      osc_enable <= 1'b1;
      pin_hold <= 1'b0;
      watchdog_clear <= 1'b0;
      device_reset <= 1'b1;
      branch_vector <= 1'b0;
      fetch_addr <= '0;
    end else begin
      // Clear pin resets; awake watchdog resets
      device_reset <= ~master_clear_b_s | (wdog_hit & (state != SWC_SLEEP)); // R2 R15
      // Sleep clears watchdog, a no-op sleep does not
      watchdog_clear <= sleep_go | watchdog_clear_instr; // R14 R11 R13
      core_halt <= (state == SWC_SLEEP) ? ~(wake_req | wdog_hit) : sleep_go;
      osc_enable <= (state == SWC_SLEEP) ? (wake_req | wdog_hit) : ~sleep_go; // R14
      pin_hold <= (state == SWC_SLEEP) ? ~(wake_req | wdog_hit) : sleep_go; // R14
      branch_vector <= (state == SWC_POST) & wake_irq & ctrl[CTRL_GLOBAL_IRQ_EN]; // R10
      if ((state == SWC_POST) && wake_irq && ctrl[CTRL_GLOBAL_IRQ_EN]) begin
        fetch_addr <= SWC_IRQ_VECTOR; // R10
      end else if (sleep_exec && state == SWC_RUN) begin
        // Address wraps at the top of program space
        fetch_addr <= 13'(pc + SWC_PC_STEP); // R8
      end
    end
  end

  // Event pulses for the interrupt status
  always_comb begin
    ev = '0;
    ev[EV_SLEEP_IN] = sleep_go;
    ev[EV_WAKE] = (state == SWC_SLEEP) & (wake_req | wdog_hit);
    ev[EV_WDOG_RST] = wdog_hit & (state != SWC_SLEEP);
    ev[EV_NOP_SLEEP] = sleep_nop;
  end

  // Control and enable registers
  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      ctrl <= CTRL_RST;
      src_en <= SRC_EN_RST;
      irq_mask <= '0;
    end else if (wb_wr) begin
      if (wb_adr_i == SWC_CTRL_OFS) begin
        ctrl <= 4'(swc_merge(32'(ctrl), wb_dat_i, wb_sel_i));
      end
      if (wb_adr_i == SWC_SRC_EN_OFS) begin
        src_en <= SWC_NSRC'(swc_merge(32'(src_en), wb_dat_i, wb_sel_i));
      end
      if (wb_adr_i == SWC_IRQ_MASK_OFS) begin
        irq_mask <= SWC_NEV'(swc_merge(32'(irq_mask), wb_dat_i, wb_sel_i));
      end
    end
  end

  // Sticky events; a new event beats a write-one clear
  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      irq_stat <= '0;
    end else if (wb_wr && wb_adr_i == SWC_IRQ_STAT_OFS && wb_sel_i[0]) begin
      irq_stat <= (irq_stat & ~wb_dat_i[SWC_NEV-1:0]) | ev;
    end else begin
      irq_stat <= irq_stat | ev;
    end
  end

  // Interrupt output level
  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      irq <= 1'b0;
    end else begin
      irq <= |(irq_stat & irq_mask);
    end
  end

  // Bus answer one cycle after the request; unmapped reads zero
  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      wb_ack_o <= 1'b0;
      wb_dat_o <= '0;
    end else begin
      wb_ack_o <= wb_cyc_i & wb_stb_i & ~wb_ack_o;
      if (wb_rd) begin
        unique case (wb_adr_i)
          SWC_CTRL_OFS: wb_dat_o <= 32'(ctrl);
          SWC_STAT_OFS: wb_dat_o <= 32'({wake_wdog, wake_irq, state == SWC_SLEEP, powerdown_flag, timeout_flag});
          SWC_IRQ_STAT_OFS: wb_dat_o <= 32'(irq_stat);
          SWC_IRQ_MASK_OFS: wb_dat_o <= 32'(irq_mask);
          SWC_SRC_EN_OFS: wb_dat_o <= 32'(src_en);
          default: wb_dat_o <= '0;
        endcase
      end
    end
  end

  // Checks
  a_nop_keeps_powerdown: assert property (@(posedge clk) disable iff (!rst_b)
    sleep_nop && !watchdog_clear_instr |=> powerdown_flag == $past(powerdown_flag)) // R11
    else $error("no-op sleep changed power-down flag");
  a_sleep_clears_flags: assert property (@(posedge clk) disable iff (!rst_b)
    sleep_go && master_clear_b_s |=> !powerdown_flag && timeout_flag && watchdog_clear) // R3
    else $error("sleep did not set flags");
  a_wdog_wake_timeout: assert property (@(posedge clk) disable iff (!rst_b)
    state == SWC_SLEEP && wdog_hit && master_clear_b_s && !watchdog_clear_instr |=> !timeout_flag ##1 state == SWC_RUN) // R4
    else $error("watchdog wake did not clear time-out");
  a_wake_quick: assert property (@(posedge clk) disable iff (!rst_b)
    state == SWC_SLEEP && wake_req && master_clear_b_s |=> state == SWC_POST && osc_enable) // R12
    else $error("interrupt did not wake");
  a_clear_pin_resets: assert property (@(posedge clk) disable iff (!rst_b)
    !master_clear_b_s |=> device_reset && state == SWC_RUN) // R2
    else $error("clear pin did not reset");
  a_awake_wdog_rst: assert property (@(posedge clk) disable iff (!rst_b)
    wdog_hit && state == SWC_RUN |=> device_reset) // R15
    else $error("awake watchdog did not reset");
  a_vector_global_en: assert property (@(posedge clk) disable iff (!rst_b)
    branch_vector |-> $past(ctrl[CTRL_GLOBAL_IRQ_EN]) && fetch_addr == SWC_IRQ_VECTOR) // R10
    else $error("vector without global enable");
  a_prefetch_next: assert property (@(posedge clk) disable iff (!rst_b)
    sleep_exec && state == SWC_RUN |=> fetch_addr == $past(pc) + SWC_PC_STEP) // R8
    else $error("pre-fetch address wrong");
  a_hold_asleep: assert property (@(posedge clk) disable iff (!rst_b)
    state == SWC_SLEEP && $past(state) == SWC_SLEEP |-> pin_hold && !osc_enable) // R14
    else $error("pins not held asleep");
  c_sleep_wdog: cover property (@(posedge clk) disable iff (!rst_b) state == SWC_SLEEP ##1 wdog_hit);
  c_sleep_nop: cover property (@(posedge clk) disable iff (!rst_b) sleep_nop);
  c_vector: cover property (@(posedge clk) disable iff (!rst_b) branch_vector);
  c_clear_pin_asleep: cover property (@(posedge clk) disable iff (!rst_b) state == SWC_SLEEP && !master_clear_b_s);
endmodule : swc_top
`default_nettype wire

// ===== test/swc_far_model.sv
// Far side model: watchdog timer that counts only while wd_run is high, and sticky interrupt flag sources
`timescale 1ns/1ps
`default_nettype none
module swc_far_model #(
  parameter int WD_PERIOD = 40
) (
  input wire logic clk,
  input wire logic rst_b,
  input wire logic watchdog_clear,
  input wire logic wd_run,
  input wire logic [11:0] src_set,
  input wire logic src_clr,
  output logic watchdog_timeout,
  output logic [11:0] irq_flags
);
  int cnt; // Watchdog count, runs on its own oscillator
  // Cleared by the block, keeps counting while the core sleeps
  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) cnt <= 0;
    else if (watchdog_clear || !wd_run) cnt <= 0;
    else cnt <= (cnt == WD_PERIOD + 4) ? 0 : cnt + 1;
  end
  // Level held four cycles so the synchroniser cannot miss it
  assign watchdog_timeout = cnt > WD_PERIOD;
  // Flags are sticky until software clears them
  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) irq_flags <= 12'h000;
    else if (src_clr) irq_flags <= 12'h000;
    else irq_flags <= irq_flags | src_set;
  end
endmodule : swc_far_model
`default_nettype wire

// ===== test/test_swc_top.sv
// Self-checking bench for the sleep and wake-up controller
`timescale 1ns/1ps
`default_nettype none
`define SWC_CHK(a, e) begin n_checks++; if ((a) !== (e)) begin failures++; \
  $display("CHECK FAILED %0t got %h exp %h", $time, a, e); end end
module test_swc_top
  import swc_pkg::*;
;
  localparam int WDP = 40; // Short watchdog period keeps the run brief
  logic clk, rst_b, cyc, stb, we, sleep_exec, wci, pin_b, wd_run, src_clr, wdog_out;
  logic [7:0] adr, lfsr;
  logic [31:0] dat, dat_o;
  logic [12:0] pc, fetch_addr;
  logic [11:0] src_set, flags;
  logic ack, core_halt, osc_enable, pin_hold, watchdog_clear, device_reset;
  logic branch_vector, timeout_flag, powerdown_flag, irq;
  int failures, n_checks, nbv, ndr, nwc;
  logic [31:0] expq[$]; // Expected read data, oldest first
  // Hard cases: clock-gated sources, each in a blocking mode and all but the clocked one in an allowing mode
  int ts[7] = '{SRC_TIMER_ONE, SRC_TIMER_ONE, SRC_SPECIAL_TRIG, SRC_SPECIAL_TRIG, SRC_ADC, SRC_ADC, SRC_CLOCKED};
  logic [3:0] tc[7] = '{4'h1, 4'h5, 4'h1, 4'h5, 4'h1, 4'h9, 4'hf};
  bit tw[7] = '{0, 1, 0, 1, 0, 1, 0};
  swc_top dut (.clk(clk), .rst_b(rst_b), .wb_cyc_i(cyc), .wb_stb_i(stb), .wb_we_i(we), .wb_adr_i(adr),
    .wb_sel_i(4'hf), .wb_dat_i(dat), .wb_dat_o(dat_o), .wb_ack_o(ack), .sleep_exec(sleep_exec),
    .watchdog_clear_instr(wci), .pc(pc), .master_clear_pin_b(pin_b), .watchdog_timeout(wdog_out),
    .irq_flags(flags), .fetch_addr(fetch_addr), .core_halt(core_halt), .osc_enable(osc_enable),
    .pin_hold(pin_hold), .watchdog_clear(watchdog_clear), .device_reset(device_reset),
    .branch_vector(branch_vector), .timeout_flag(timeout_flag), .powerdown_flag(powerdown_flag), .irq(irq));
  swc_far_model #(.WD_PERIOD(WDP)) far (.clk(clk), .rst_b(rst_b), .watchdog_clear(watchdog_clear),
    .wd_run(wd_run), .src_set(src_set), .src_clr(src_clr), .watchdog_timeout(wdog_out), .irq_flags(flags));
  always #10 clk = ~clk;
  function automatic logic [7:0] nxt(input logic [7:0] v);
    return {v[6:0], v[7] ^ v[5] ^ v[4] ^ v[3]};
  endfunction : nxt
  // Watcher: read data against notes, pulse counters
  always @(posedge clk) begin
    if (ack === 1'b1 && !we) `SWC_CHK(dat_o, expq.pop_front())
    if (branch_vector === 1'b1) begin
      nbv++;
      `SWC_CHK(fetch_addr, SWC_IRQ_VECTOR)
    end
    if (device_reset === 1'b1 && rst_b) ndr++;
    if (watchdog_clear === 1'b1) nwc++;
  end
  // One classic cycle; held until ack is sampled high
  // No cycle count assumed; only the bench watchdog ends a hung wait
  task automatic xfer(input logic w, input logic [7:0] a, input logic [31:0] d);
    @(posedge clk) begin cyc <= 1; stb <= 1; we <= w; adr <= a; dat <= d; end
    do @(posedge clk); while (ack !== 1'b1);
    cyc <= 0;
    stb <= 0;
  endtask : xfer
  task automatic rd(input logic [7:0] a, input logic [31:0] e);
    expq.push_back(e);
    xfer(0, a, 32'h0);
  endtask : rd
  task automatic pulse(input int k);
    @(posedge clk) begin if (k == 0) wci <= 1; else if (k == 1) sleep_exec <= 1; else src_clr <= 1; end
    @(posedge clk) begin wci <= 0; sleep_exec <= 0; src_clr <= 0; end
    #1;
  endtask : pulse
  task automatic raise(input int s);
    @(posedge clk) src_set <= 12'h001 << s;
    @(posedge clk) src_set <= 12'h000;
  endtask : raise
  // Real sleep, then one source; wakes or falls back to a watchdog wake
  task automatic sleep_wake(input int s, input logic [3:0] c, input bit wk);
    int b0, d0;
    xfer(1, SWC_CTRL_OFS, {28'h0, c});
    pulse(0);
    lfsr = nxt(lfsr);
    pc <= {5'h00, lfsr};
    b0 = nbv;
    d0 = ndr;
    pulse(1);
    `SWC_CHK(fetch_addr, pc + SWC_PC_STEP)
    `SWC_CHK({powerdown_flag, timeout_flag, core_halt, osc_enable, pin_hold, watchdog_clear}, 6'h1b)
    raise(s);
    repeat (10) @(posedge clk);
    #1 `SWC_CHK(core_halt, !wk)
    `SWC_CHK(irq, 1'b1)
    if (wk) begin
      `SWC_CHK({timeout_flag, powerdown_flag}, 2'h2)
      `SWC_CHK(nbv - b0, int'(c[1]))
    end else begin
      @(posedge clk) wd_run <= 1;
      repeat (WDP + 12) @(posedge clk);
      #1 `SWC_CHK({core_halt, timeout_flag}, 2'h0)
      @(posedge clk) wd_run <= 0;
      rd(SWC_STAT_OFS, 32'h10);
    end
    `SWC_CHK(ndr, d0)
    pulse(2);
    xfer(1, SWC_IRQ_STAT_OFS, 32'hf);
    repeat (6) @(posedge clk);
    #1 `SWC_CHK(irq, 1'b0)
  endtask : sleep_wake
  task automatic print_verdict();
    if (failures == 0 && n_checks > 0) $display("RESULT: PASS");
    else $display("RESULT: FAIL");
    $finish;
  endtask : print_verdict
  initial begin
    repeat (10000) @(posedge clk);
    failures++;
    print_verdict();
  end
  initial begin
    {clk, rst_b, cyc, stb, we, sleep_exec, wci, wd_run, src_clr} = '0;
    {adr, dat, pc, src_set} = '0;
    pin_b = 1;
    lfsr = 8'h5f;
    repeat (5) @(posedge clk);
    `SWC_CHK({timeout_flag, powerdown_flag, device_reset}, 3'h7)
    rst_b <= 1;
    repeat (8) @(posedge clk);
    rd(SWC_CTRL_OFS, {28'h0, CTRL_RST});
    rd(SWC_STAT_OFS, 32'h3);
    xfer(1, 8'h40, 32'hffffffff);
    rd(8'h40, 32'h0);
    xfer(1, SWC_IRQ_MASK_OFS, 32'h1);
    xfer(1, SWC_SRC_EN_OFS, 32'hfff);
    for (int i = 0; i < 8; i++) sleep_wake(i, {2'h0, lfsr[0], 1'h1}, 1);
    for (int i = 0; i < 7; i++) sleep_wake(ts[i], tc[i], tw[i]);
    xfer(1, SWC_SRC_EN_OFS, 32'hffe);
    sleep_wake(SRC_EXT_PIN, 4'h3, 0);
    // Enabled flag already pending: sleep must do nothing
    xfer(1, SWC_CTRL_OFS, 32'h1);
    pulse(0);
    raise(SRC_PORT_CHG);
    repeat (6) @(posedge clk);
    nbv = nwc;
    pulse(1);
    repeat (2) @(posedge clk);
    #1 `SWC_CHK({powerdown_flag, timeout_flag, core_halt, irq}, 4'hc)
    `SWC_CHK(nwc, nbv)
    pulse(2);
    // Awake watchdog expiry resets the device
    nbv = ndr;
    @(posedge clk) wd_run <= 1;
    repeat (WDP + 12) @(posedge clk);
    wd_run <= 0;
    `SWC_CHK(ndr > nbv, 1'b1)
    repeat (10) @(posedge clk);
    // Watchdog disabled: its time-out must not wake the sleeping core
    xfer(1, SWC_CTRL_OFS, 32'h0);
    pulse(1);
    @(posedge clk) wd_run <= 1;
    repeat (WDP + 12) @(posedge clk);
    #1 `SWC_CHK({core_halt, timeout_flag, device_reset}, 3'h6)
    @(posedge clk) wd_run <= 0;
    // Clear pin while asleep gives a full reset, flags kept
    @(posedge clk) pin_b <= 0;
    repeat (6) @(posedge clk);
    #1 `SWC_CHK({device_reset, core_halt, powerdown_flag}, 3'h4)
    @(posedge clk) pin_b <= 1;
    repeat (8) @(posedge clk);
    print_verdict();
  end
endmodule : test_swc_top
`default_nettype wire
